// ### design/dsp_stage.sv
// constants package and the bypassable, source-selected register stage
`timescale 1ns/10ps
`default_nettype none

package dsp_slice_pkg;
    localparam int OP_W_DEF = 18;
    localparam int ACC_W_DEF = 52;
    localparam int NUM_SRC = 4;
    localparam int SEL_W = 2;
    localparam logic [1:0] SEL_RESET = 2'h0;
    localparam logic STAGE_USE_RESET = 1'h0;
    localparam logic FLAG_RESET = 1'h0;
endpackage

module dsp_stage
    import dsp_slice_pkg::*;
#(
    parameter int W = OP_W_DEF
) (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic [NUM_SRC-1:0] tick_src,
    input wire logic [NUM_SRC-1:0] ce_src,
    input wire logic [NUM_SRC-1:0] rst_src,
    input wire logic [SEL_W-1:0] tick_sel,
    input wire logic [SEL_W-1:0] ce_sel,
    input wire logic [SEL_W-1:0] rst_sel,
    input wire logic use_reg,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] hold_q;

    // refused at elaboration, before any logic is built
    if (W < 1) begin : g_width_check
        $error("dsp_stage width must be at least 1");
    end

    // clock, enable and reset each picked from their own source set
    always_ff @(posedge clock) begin
        if (!rst_b || rst_src[rst_sel]) begin
            hold_q <= '0;
        end else if (tick_src[tick_sel] && ce_src[ce_sel]) begin
            hold_q <= d;
        end
    end

    // bypass leaves the stage transparent
    always_comb begin
        q = use_reg ? hold_q : d;
    end
endmodule

`default_nettype wire

// ### design/dsp_mac_slice_flags.sv
// multiply-accumulate / multiply-add-sub slice with ALU result flags
`timescale 1ns/10ps
`default_nettype none

module dsp_mac_slice_flags
    import dsp_slice_pkg::*;
#(
    parameter int OP_W = OP_W_DEF,
    parameter int ACC_W = ACC_W_DEF
) (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic fabric_clock_0,
    input wire logic fabric_clock_1,
    input wire logic fabric_clock_2,
    input wire logic fabric_clock_3,
    input wire logic [NUM_SRC-1:0] fabric_ce,
    input wire logic [NUM_SRC-1:0] fabric_reset,
    input wire logic [SEL_W-1:0] in_tick_sel,
    input wire logic [SEL_W-1:0] in_ce_sel,
    input wire logic [SEL_W-1:0] in_rst_sel,
    input wire logic [SEL_W-1:0] pipe_tick_sel,
    input wire logic [SEL_W-1:0] pipe_ce_sel,
    input wire logic [SEL_W-1:0] pipe_rst_sel,
    input wire logic [SEL_W-1:0] out_tick_sel,
    input wire logic [SEL_W-1:0] out_ce_sel,
    input wire logic [SEL_W-1:0] out_rst_sel,
    input wire logic in_reg_en,
    input wire logic pipe_reg_en,
    input wire logic out_reg_en,
    input wire logic dual_product_add_sub_mode,
    input wire logic subtract_select,
    input wire logic accum_load,
    input wire logic [ACC_W-1:0] accum_load_value,
    input wire logic [ACC_W-1:0] flag_mask,
    input wire logic [ACC_W-1:0] flag_pattern,
    input wire logic [OP_W-1:0] first_pair_operand_a,
    input wire logic [OP_W-1:0] first_pair_operand_b,
    input wire logic [OP_W-1:0] second_pair_operand_a,
    input wire logic [OP_W-1:0] second_pair_operand_b,
    output logic [ACC_W-1:0] result,
    output logic result_zero_flag,
    output logic masked_zero_flag,
    output logic masked_ones_flag,
    output logic pattern_match_flag,
    output logic inverse_pattern_match_flag,
    output logic accum_overflow_flag,
    output logic accum_underflow_flag,
    output logic accum_range_error_flag
);
    localparam int P_W = 2 * OP_W;

    logic [NUM_SRC-1:0] ticks;
    logic [4*OP_W-1:0] ops_q;
    logic [2*P_W-1:0] prod_d;
    logic [2*P_W-1:0] prod_q;
    logic [ACC_W-1:0] p0_ext;
    logic [ACC_W-1:0] p1_ext;
    logic [ACC_W:0] acc_wide;
    logic [ACC_W-1:0] sum_d;
    logic over_d;
    logic under_d;
    logic out_hit;
    logic out_rst;
    logic out_load;

    // widths the datapath cannot serve are refused at elaboration
    if (OP_W < 2) begin : g_op_width_check
        $error("operand width too small");
    end
    if (ACC_W < P_W + 1) begin : g_acc_width_check
        $error("accumulator narrower than a product plus sign");
    end

    always_comb begin
        ticks = {fabric_clock_3, fabric_clock_2, fabric_clock_1, fabric_clock_0};
    end

    // all four operands share one input stage selection
    dsp_stage #(.W(4 * OP_W)) u_in_stage (
        .clock(clock),
        .rst_b(rst_b),
        .tick_src(ticks),
        .ce_src(fabric_ce),
        .rst_src(fabric_reset),
        .tick_sel(in_tick_sel),
        .ce_sel(in_ce_sel),
        .rst_sel(in_rst_sel),
        .use_reg(in_reg_en),
        .d({second_pair_operand_b, second_pair_operand_a, first_pair_operand_b, first_pair_operand_a}),
        .q(ops_q)
    );

    always_comb begin
        prod_d[P_W-1:0] = P_W'($signed(ops_q[OP_W-1:0]) * $signed(ops_q[2*OP_W-1:OP_W]));
        prod_d[2*P_W-1:P_W] = P_W'($signed(ops_q[3*OP_W-1:2*OP_W]) * $signed(ops_q[4*OP_W-1:3*OP_W]));
    end

    dsp_stage #(.W(2 * P_W)) u_pipe_stage (
        .clock(clock),
        .rst_b(rst_b),
        .tick_src(ticks),
        .ce_src(fabric_ce),
        .rst_src(fabric_reset),
        .tick_sel(pipe_tick_sel),
        .ce_sel(pipe_ce_sel),
        .rst_sel(pipe_rst_sel),
        .use_reg(pipe_reg_en),
        .d(prod_d),
        .q(prod_q)
    );

    always_comb begin
        p0_ext = {{(ACC_W-P_W){prod_q[P_W-1]}}, prod_q[P_W-1:0]};
        p1_ext = {{(ACC_W-P_W){prod_q[2*P_W-1]}}, prod_q[2*P_W-1:P_W]};
        // one extra bit tells the sign a wrapped sum should have had
        acc_wide = {result[ACC_W-1], result} + {p0_ext[ACC_W-1], p0_ext};
        over_d = 1'h0;
        under_d = 1'h0;
        if (dual_product_add_sub_mode) begin
            sum_d = subtract_select ? ACC_W'(p0_ext - p1_ext) : ACC_W'(p0_ext + p1_ext);
        end else if (accum_load) begin
            sum_d = accum_load_value;
        end else begin
            sum_d = acc_wide[ACC_W-1:0];
            over_d = (acc_wide[ACC_W] != acc_wide[ACC_W-1]) && !acc_wide[ACC_W];
            under_d = (acc_wide[ACC_W] != acc_wide[ACC_W-1]) && acc_wide[ACC_W];
        end
    end

    always_comb begin
        out_hit = ticks[out_tick_sel] && fabric_ce[out_ce_sel];
        out_rst = fabric_reset[out_rst_sel];
        // in dual-product mode a bypassed output stage simply follows every system clock
        out_load = (!dual_product_add_sub_mode || out_reg_en) ? out_hit : 1'h1;
    end

    always_ff @(posedge clock) begin
        if (!rst_b || out_rst) begin
            result <= '0;
        end else if (out_load) begin
            result <= sum_d;
        end
    end

    // flags computed from the value being loaded so they stay aligned with it
    always_ff @(posedge clock) begin
        if (!rst_b || out_rst) begin
            result_zero_flag <= 1'h1;
            masked_zero_flag <= 1'h1;
            masked_ones_flag <= (flag_mask == '1);
            pattern_match_flag <= ((flag_pattern & ~flag_mask) == '0);
            inverse_pattern_match_flag <= ((~flag_pattern & ~flag_mask) == '0);
            accum_overflow_flag <= FLAG_RESET;
            accum_underflow_flag <= FLAG_RESET;
            accum_range_error_flag <= FLAG_RESET;
        end else if (out_load) begin
            result_zero_flag <= (sum_d == '0);
            masked_zero_flag <= ((sum_d & ~flag_mask) == '0);
            masked_ones_flag <= ((sum_d | flag_mask) == '1);
            pattern_match_flag <= (((sum_d ^ flag_pattern) & ~flag_mask) == '0);
            inverse_pattern_match_flag <= (((sum_d ^ ~flag_pattern) & ~flag_mask) == '0);
            accum_overflow_flag <= over_d;
            accum_underflow_flag <= under_d;
            accum_range_error_flag <= over_d || under_d;
        end
    end

    property p_acc_add;
        @(posedge clock) disable iff (!rst_b)
        (!dual_product_add_sub_mode && !accum_load && out_hit && !out_rst)
            |=> result == ACC_W'($past(result) + $past(p0_ext));
    endproperty
    a_acc_add: assert property (p_acc_add) else $error("accumulate sum wrong");

    property p_acc_hold;
        @(posedge clock) disable iff (!rst_b)
        (!dual_product_add_sub_mode && !out_hit && !out_rst) |=> $stable(result) && $stable(accum_overflow_flag);
    endproperty
    a_acc_hold: assert property (p_acc_hold) else $error("accumulator moved without output edge");

    property p_acc_load;
        @(posedge clock) disable iff (!rst_b)
        (!dual_product_add_sub_mode && accum_load && out_hit && !out_rst)
            |=> result == $past(accum_load_value) && !accum_range_error_flag;
    endproperty
    a_acc_load: assert property (p_acc_load) else $error("accumulator load failed");

    property p_dual;
        @(posedge clock) disable iff (!rst_b)
        (dual_product_add_sub_mode && !out_reg_en && !out_rst)
            |=> result == ($past(subtract_select) ? ACC_W'($past(p0_ext) - $past(p1_ext))
                                                  : ACC_W'($past(p0_ext) + $past(p1_ext)));
    endproperty
    a_dual: assert property (p_dual) else $error("dual product result wrong");

    property p_zero;
        @(posedge clock) disable iff (!rst_b)
        result_zero_flag == (result == '0);
    endproperty
    a_zero: assert property (p_zero) else $error("zero flag disagrees with result");

    property p_mzero;
        @(posedge clock) disable iff (!rst_b)
        $stable(flag_mask) && $past(rst_b) |-> masked_zero_flag == ((result & ~flag_mask) == '0);
    endproperty
    a_mzero: assert property (p_mzero) else $error("masked zero flag wrong");

    property p_mones;
        @(posedge clock) disable iff (!rst_b)
        $stable(flag_mask) && $past(rst_b) |-> masked_ones_flag == ((result | flag_mask) == '1);
    endproperty
    a_mones: assert property (p_mones) else $error("masked ones flag wrong");

    property p_pat;
        @(posedge clock) disable iff (!rst_b)
        $stable(flag_mask) && $stable(flag_pattern) && $past(rst_b)
            |-> pattern_match_flag == (((result ^ flag_pattern) & ~flag_mask) == '0)
             && inverse_pattern_match_flag == (((result ^ ~flag_pattern) & ~flag_mask) == '0);
    endproperty
    a_pat: assert property (p_pat) else $error("pattern flags wrong");

    property p_range;
        @(posedge clock) disable iff (!rst_b)
        !(accum_overflow_flag && accum_underflow_flag)
            && accum_range_error_flag == (accum_overflow_flag || accum_underflow_flag);
    endproperty
    a_range: assert property (p_range) else $error("range flags inconsistent");
endmodule

`default_nettype wire

// ### test/fabric_user_model.sv
// fabric-side partner that makes the four stage tick pulses
`timescale 1ns/10ps
`default_nettype none
module fabric_user_model (
    input wire logic [3:0] hold,
    output logic [3:0] tick
);
    // a held source stops ticking, so any stage that picks it stalls unless bypassed (the output stage only in dual-product mode)
    always_comb begin
        tick = ~hold;
    end
endmodule
`default_nettype wire

// ### test/dsp_mac_slice_flags_test.sv
// directed bench for the multiply-accumulate slice and its flags
`timescale 1ns/10ps
`default_nettype none
`define chk(g, e) begin checked++; if ((g) !== (e)) begin mismatches++; $display("wrong value at %0t: got %h exp %h", $time, g, e); end end
module dsp_mac_slice_flags_test;
    import dsp_slice_pkg::*;
    logic clock, rst_b, in_reg_en, pipe_reg_en, out_reg_en, dual_product_add_sub_mode, subtract_select, accum_load;
    logic [3:0] fabric_ce, fabric_reset, hold, tick;
    logic [1:0] in_tick_sel, in_ce_sel, in_rst_sel, pipe_tick_sel, pipe_ce_sel, pipe_rst_sel;
    logic [1:0] out_tick_sel, out_ce_sel, out_rst_sel;
    logic [51:0] accum_load_value, flag_mask, flag_pattern, result, m;
    logic [17:0] first_pair_operand_a, first_pair_operand_b, second_pair_operand_a, second_pair_operand_b;
    logic result_zero_flag, masked_zero_flag, masked_ones_flag, pattern_match_flag, inverse_pattern_match_flag;
    logic accum_overflow_flag, accum_underflow_flag, accum_range_error_flag;
    int mismatches, checked, cycles;

    fabric_user_model u_fab (.hold, .tick);
    dsp_mac_slice_flags u_dut (.clock, .rst_b, .fabric_clock_0(tick[0]), .fabric_clock_1(tick[1]),
        .fabric_clock_2(tick[2]), .fabric_clock_3(tick[3]), .fabric_ce, .fabric_reset, .in_tick_sel, .in_ce_sel,
        .in_rst_sel, .pipe_tick_sel, .pipe_ce_sel, .pipe_rst_sel, .out_tick_sel, .out_ce_sel, .out_rst_sel,
        .in_reg_en, .pipe_reg_en, .out_reg_en, .dual_product_add_sub_mode, .subtract_select, .accum_load,
        .accum_load_value, .flag_mask, .flag_pattern, .first_pair_operand_a, .first_pair_operand_b,
        .second_pair_operand_a, .second_pair_operand_b, .result, .result_zero_flag, .masked_zero_flag,
        .masked_ones_flag, .pattern_match_flag, .inverse_pattern_match_flag, .accum_overflow_flag,
        .accum_underflow_flag, .accum_range_error_flag);

    initial begin
        clock = 1'h0;
        forever #10 clock = ~clock;
    end

    task automatic end_sim();
        $display("mismatches %0d checked %0d", mismatches, checked);
        if (mismatches == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // whole run is well under a hundred cycles
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 500) begin
            mismatches++;
            $display("wrong value at %0t: timeout", $time);
            end_sim();
        end
    end

    // drives at an edge; the following edge samples it
    task automatic drive(input logic [17:0] a, b, input logic ld = 1'h0, input logic [51:0] v = 52'h0);
        @(posedge clock);
        first_pair_operand_a <= a;
        first_pair_operand_b <= b;
        accum_load <= ld;
        accum_load_value <= v;
    endtask

    task automatic chk_out(input logic [51:0] e);
        m = ~flag_mask;
        `chk(result, e)
        `chk(result_zero_flag, e == 0)
        `chk(masked_zero_flag, (e & m) == 0)
        `chk(masked_ones_flag, (e & m) == m)
        `chk(pattern_match_flag, ((e ^ flag_pattern) & m) == 0)
        `chk(inverse_pattern_match_flag, ((e ^ ~flag_pattern) & m) == 0)
    endtask

    task automatic chk_rng(input logic o, u);
        `chk(accum_overflow_flag, o)
        `chk(accum_underflow_flag, u)
        `chk(accum_range_error_flag, o | u)
    endtask

    task automatic t_accum();
        drive(18'h3, 18'h3fffe, 1'h1, 52'h64);
        drive(18'h3, 18'h3fffe); #1 chk_out(52'h64);
        drive(18'h3, 18'h3fffe); #1 chk_out(52'h5e);
        drive(18'h3, 18'h3fffe); #1 chk_out(52'h58);
    endtask

    task automatic t_ovf();
        drive(18'h1, 18'h1, 1'h1, 52'h7ffffffffffff);
        in_reg_en <= 1'h0;
        pipe_reg_en <= 1'h0;
        drive(18'h1, 18'h1); #1 chk_out(52'h7ffffffffffff); chk_rng(1'h0, 1'h0);
        drive(18'h3ffff, 18'h1, 1'h1, 52'h8000000000000); #1 chk_out(52'h8000000000000); chk_rng(1'h1, 1'h0);
        drive(18'h3ffff, 18'h1); #1 chk_out(52'h8000000000000);
        drive(18'h0, 18'h0); #1 chk_out(52'h7ffffffffffff); chk_rng(1'h0, 1'h1);
    endtask

    // all stages registered: a one-cycle pulse shows three edges later
    task automatic lat3();
        drive(18'h0, 18'h0, 1'h1);
        in_reg_en <= 1'h1;
        pipe_reg_en <= 1'h1;
        out_reg_en <= 1'h1;
        repeat (3) drive(18'h0, 18'h0, 1'h1);
        drive(18'h5, 18'h1);
        repeat (2) begin
            drive(18'h0, 18'h0); #1 chk_out(52'h0);
        end
        drive(18'h0, 18'h0); #1 chk_out(52'h5);
    endtask

    task automatic t_dual();
        logic [51:0] vals [5] = '{52'h5, 52'ha, 52'h0, 52'hf, 52'h10};
        drive(18'h0, 18'h0);
        dual_product_add_sub_mode <= 1'h1;
        in_reg_en <= 1'h0;
        pipe_reg_en <= 1'h0;
        out_reg_en <= 1'h0;
        second_pair_operand_a <= 18'h2;
        second_pair_operand_b <= 18'h5;
        drive(18'h7, 18'h3);
        drive(18'h7, 18'h3); subtract_select <= 1'h1; #1 chk_out(52'h1f); chk_rng(1'h0, 1'h0);
        drive(18'h7, 18'h3); subtract_select <= 1'h0; second_pair_operand_a <= 18'h0; #1 chk_out(52'hb);
        foreach (vals[i]) begin
            drive(vals[i][17:0], 18'h1);
            drive(vals[i][17:0], 18'h1); #1 chk_out(vals[i]);
        end
    endtask

    task automatic t_enable();
        drive(18'h1, 18'h1, 1'h1, 52'h20);
        dual_product_add_sub_mode <= 1'h0;
        in_reg_en <= 1'h0;
        pipe_reg_en <= 1'h0;
        out_tick_sel <= 2'h2;
        out_ce_sel <= 2'h1;
        out_rst_sel <= 2'h3;
        drive(18'h1, 18'h1); hold <= 4'h4; #1 chk_out(52'h20);
        drive(18'h1, 18'h1); hold <= 4'h1; fabric_ce <= 4'hd; #1 chk_out(52'h20);
        drive(18'h1, 18'h1); fabric_ce <= 4'hf; fabric_reset <= 4'h8; #1 chk_out(52'h20);
        drive(18'h1, 18'h1); fabric_reset <= 4'h0; #1 chk_out(52'h0);
        drive(18'h1, 18'h1); #1 chk_out(52'h1);
    endtask

    initial begin
        mismatches = 0;
        checked = 0;
        cycles = 0;
        rst_b = 1'h0;
        fabric_ce = 4'hf;
        fabric_reset = 4'h0;
        hold = 4'h0;
        {in_tick_sel, in_ce_sel, in_rst_sel, pipe_tick_sel, pipe_ce_sel, pipe_rst_sel} = 12'h0;
        {out_tick_sel, out_ce_sel, out_rst_sel} = 6'h0;
        {in_reg_en, pipe_reg_en, out_reg_en} = 3'h1;
        {dual_product_add_sub_mode, subtract_select, accum_load} = 3'h0;
        accum_load_value = 52'h0;
        flag_mask = 52'hffffffffffff0;
        flag_pattern = 52'h5;
        {first_pair_operand_a, first_pair_operand_b, second_pair_operand_a, second_pair_operand_b} = 72'h0;
        repeat (2) @(posedge clock);
        rst_b <= 1'h1;
        #1 chk_out(52'h0); chk_rng(1'h0, 1'h0);
        t_accum();
        t_ovf();
        lat3();
        t_dual();
        lat3();
        t_enable();
        end_sim();
    end
endmodule
`default_nettype wire
